/* File: hdl/pmr_pkg.sv */
/*
  pmr_pkg: constants, register map, field layout, mode enumeration and
  carrier structs for the power-mode and reset sequencer.
  Assumes a single 10 MHz ref_clk and a plain register port.
*/
// Behaviour
// - in normal mode all units powered, each clocked only while in use
// - idle stops the cpu clock, peripherals keep their clocks
// - idle returns to normal on any enabled interrupt, timer ones included
// - sleep entry first puts dram in self-refresh, then shuts the rest down
// - during sleep only the real-time clock keeps running
// - sleep ends only on an interrupt configured beforehand as wake source
// - wake completes in 10 ms with oscillator kept, 160 ms otherwise
// - several reset sources merge into system reset; software can request one
// - record last reset cause: hard, software, watchdog or sleep reset
package pmr_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned WAKE_FAST_MS   = 10;
    localparam int unsigned WAKE_SLOW_MS   = 160;
    localparam int unsigned WAKE_FAST_CYC  = WAKE_FAST_MS * (CLK_HZ / 1000);
    localparam int unsigned WAKE_SLOW_CYC  = WAKE_SLOW_MS * (CLK_HZ / 1000);
    localparam int unsigned RST_PULSE_CYC  = 16;

    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_STATUS     = 4'h1;
    localparam logic [3:0] ADDR_CAUSE      = 4'h2;
    localparam logic [3:0] ADDR_WAKE_EN    = 4'h3;
    localparam logic [3:0] ADDR_CLK_REQ    = 4'h4;
    localparam logic [3:0] ADDR_EVT_STAT   = 4'h5;
    localparam logic [3:0] ADDR_EVT_CLR    = 4'h6;
    localparam logic [3:0] ADDR_EVT_EN     = 4'h7;

    // control register fields (write-one actions plus one setting)
    localparam int unsigned CTRL_IDLE_BIT  = 0;
    localparam int unsigned CTRL_SLEEP_BIT = 1;
    localparam int unsigned CTRL_SWRST_BIT = 2;
    localparam int unsigned CTRL_OSC_BIT   = 3;
    localparam logic        OSC_KEEP_RST   = 1'b1;

    // reset cause bits
    localparam int unsigned CAUSE_HARD     = 0;
    localparam int unsigned CAUSE_SOFT     = 1;
    localparam int unsigned CAUSE_WDOG     = 2;
    localparam int unsigned CAUSE_SLEEP    = 3;
    localparam logic [3:0]  CAUSE_RST      = 4'h1;

    // event bits
    localparam int unsigned EVT_IDLE_WAKE  = 0;
    localparam int unsigned EVT_SLEEP_WAKE = 1;
    localparam int unsigned EVT_SR_DONE    = 2;
    localparam int unsigned EVT_W          = 3;

    typedef enum logic [2:0] {
        PM_NORMAL  = 3'b000,
        PM_IDLE    = 3'b001,
        PM_SR_WAIT = 3'b011,
        PM_SLEEP   = 3'b010,
        PM_WAKE    = 3'b110
    } pmr_mode_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } pmr_bus_type;

    typedef struct packed {
        logic sr_req;
        logic osc_en;
        logic rtc_en;
    } pmr_power_type;
endpackage : pmr_pkg

/* File: hdl/pmr_top.sv */
/*
  pmr_top: power-mode sequencer (normal, idle, sleep), clock gating
  enables, reset merging with software reset and last-cause record.

  mode flow:
    normal   - cpu clocked, each unit clocked while busy or forced on
    idle     - cpu clock stopped, unit clocks as in normal; any enabled
               interrupt returns to normal
    sr_wait  - self-refresh requested; clocks kept until the memory
               controller acknowledges
    sleep    - only the real-time clock runs; main oscillator as set
               by the keep bit; left only on a wake-enabled interrupt
    wake     - system reset held low for the fast or slow latency,
               then normal with the sleep cause recorded

  register map (word offsets, narrow fields in low bits):
    0 control    w: b0 idle, b1 sleep, b2 soft reset, b3 osc keep (r/w)
    1 status     r: b2:0 mode code, b3 self-refresh acknowledge
    2 cause      r: one-hot b0 hard, b1 soft, b2 watchdog, b3 sleep
    3 wake mask  r/w: interrupts that may end sleep
    4 clock req  r/w: units forced to run
    5 event stat r: b0 idle wake, b1 sleep wake, b2 self-refresh done
    6 event clr  w: write one to clear, reads zero
    7 event en   r/w: events that drive irq

  reset sources:
    rst_b is the hard reset and clears everything; soft reset and
    watchdog start a stretched internal reset that keeps settings;
    neither is taken in sleep, where only the rtc is alive.

  clock gating:
    the enables are registered, so a gate follows its cause by one
    cycle; a unit that needs its clock sooner must be forced on
    through the clock request register.

  timing:
    the wake counts are parameters in ref_clk cycles; their defaults
    give the fast and slow latencies at the nominal clock rate, and a
    bench may shorten them.

  Assumes synchronous inputs on ref_clk and a memory controller that
  acknowledges self-refresh entry with a level; the register port is
  a plain one-cycle strobe bus with read data the cycle after.
*/
`timescale 1ns/1ps
module pmr_top
    import pmr_pkg::*;
#(
    parameter int unsigned NUM_UNITS     = 8,
    parameter int unsigned NUM_IRQ       = 16,
    parameter int unsigned WAKE_FAST_CNT = WAKE_FAST_CYC,
    parameter int unsigned WAKE_SLOW_CNT = WAKE_SLOW_CYC
)
(
    // clock and hard reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // register port
    input  wire pmr_bus_type          bus,
    output logic [31:0]               rdata,
    // other reset sources
    input  wire logic                 wdog_expire,
    // interrupt and unit activity
    input  wire logic [NUM_IRQ-1:0]   irq_pend,
    input  wire logic [NUM_IRQ-1:0]   irq_enable,
    input  wire logic [NUM_UNITS-1:0] unit_busy,
    // memory controller
    input  wire logic                 sr_ack,
    // clock enables and power
    output logic                      cpu_clk_en,
    output logic [NUM_UNITS-1:0]      unit_clk_en,
    output pmr_power_type             power,
    output logic                      sys_rst_b,
    output logic                      irq
);
    localparam logic [27:0] FAST_CNT = 28'(WAKE_FAST_CNT);
    localparam logic [27:0] SLOW_CNT = 28'(WAKE_SLOW_CNT);
    localparam logic [4:0]  PULSE    = 5'(RST_PULSE_CYC);

    pmr_mode_type         mode_reg;
    logic                 osc_keep_reg;
    logic [NUM_IRQ-1:0]   wake_en_reg;
    logic [NUM_UNITS-1:0] clk_req_reg;
    logic [3:0]           cause_reg;
    logic [EVT_W-1:0]     evt_reg;
    logic [EVT_W-1:0]     evt_en_reg;
    logic [27:0]          wake_cnt_reg;
    logic [4:0]           rst_cnt_reg;
    logic                 sleep_rst_reg;

    logic                 wr_ctrl;
    logic                 wr_wake;
    logic                 wr_clk_req;
    logic                 wr_evt_en;
    logic                 wr_evt_clr;
    logic                 rst_allow;
    logic                 clk_mode_on;
    logic [31:0]          rd_mux;
    logic                 any_irq;
    logic                 any_wake;
    logic                 int_rst;
    logic [EVT_W-1:0]     evt_set;

    // decode and wake conditions
    assign wr_ctrl  = bus.wr && bus.addr == ADDR_CTRL;
    assign wr_wake  = bus.wr && bus.addr == ADDR_WAKE_EN;
    assign wr_clk_req = bus.wr && bus.addr == ADDR_CLK_REQ;
    assign wr_evt_en  = bus.wr && bus.addr == ADDR_EVT_EN;
    assign wr_evt_clr = bus.wr && bus.addr == ADDR_EVT_CLR;
    assign any_irq  = |(irq_pend & irq_enable);
    assign any_wake = |(irq_pend & wake_en_reg);
    assign int_rst  = rst_cnt_reg != 5'h00;

    // soft reset and watchdog are ignored in sleep: only the rtc is alive
    // there, and sleep must end on a wake interrupt alone
    assign rst_allow = !int_rst && mode_reg != PM_SLEEP;
    // units may be clocked in every mode where the system is up
    assign clk_mode_on = mode_reg == PM_NORMAL || mode_reg == PM_IDLE
                         || mode_reg == PM_SR_WAIT;

    // mode sequencer; internal reset returns it to normal
    // sleep is only entered through sr_wait, so clocks never drop while
    // the memory still needs refresh from the controller
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            mode_reg <= PM_NORMAL;
        else if (int_rst)
            mode_reg <= PM_NORMAL;
        else
        begin
            unique case (mode_reg)
                PM_NORMAL:
                    if (wr_ctrl && bus.wdata[CTRL_SLEEP_BIT])
                        mode_reg <= PM_SR_WAIT;
                    else if (wr_ctrl && bus.wdata[CTRL_IDLE_BIT])
                        mode_reg <= PM_IDLE;
                PM_IDLE:
                    if (any_irq)
                        mode_reg <= PM_NORMAL;
                PM_SR_WAIT:
                    if (sr_ack)
                        mode_reg <= PM_SLEEP;
                PM_SLEEP:
                    if (any_wake)
                        mode_reg <= PM_WAKE;
                PM_WAKE:
                    if (wake_cnt_reg == 28'h0000001)
                        mode_reg <= PM_NORMAL;
                default:
                    mode_reg <= PM_NORMAL;                         // unused codes recover
            endcase
        end
    end

    // wake latency counter; loaded by oscillator setting at wake start
    // a stopped oscillator needs the long count to settle before the
    // system may run again
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            wake_cnt_reg <= 28'h0000000;
        else if (mode_reg == PM_SLEEP && any_wake)
            wake_cnt_reg <= osc_keep_reg ? FAST_CNT : SLOW_CNT;
        else if (wake_cnt_reg != 28'h0000000)
            wake_cnt_reg <= wake_cnt_reg - 28'h0000001;
    end

    // sleep oscillator choice; kept across internal resets
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            osc_keep_reg <= OSC_KEEP_RST;
        else if (wr_ctrl)
            osc_keep_reg <= bus.wdata[CTRL_OSC_BIT];
    end

    // wake mask, written before sleep; only these lines end sleep
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            wake_en_reg <= '0;
        else if (wr_wake)
            wake_en_reg <= bus.wdata[NUM_IRQ-1:0];
    end

    // forced unit clocks, for units whose busy flag comes too late
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            clk_req_reg <= '0;
        else if (wr_clk_req)
            clk_req_reg <= bus.wdata[NUM_UNITS-1:0];
    end

    // event enables for the interrupt output
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            evt_en_reg <= '0;
        else if (wr_evt_en)
            evt_en_reg <= bus.wdata[EVT_W-1:0];
    end

    // internal reset stretcher: software reset or watchdog; the pulse is
    // stretched so every unit sees it, while settings stay as they were
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_cnt_reg <= 5'h00;
        else if (rst_allow && wr_ctrl && bus.wdata[CTRL_SWRST_BIT])
            rst_cnt_reg <= PULSE;
        else if (rst_allow && wdog_expire)
            rst_cnt_reg <= PULSE;
        else if (int_rst)
            rst_cnt_reg <= rst_cnt_reg - 5'h01;
    end

    // a wake from sleep restarts the system, as sleep is a reset
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            sleep_rst_reg <= 1'b0;
        else if (mode_reg == PM_SLEEP && any_wake)
            sleep_rst_reg <= 1'b1;
        else if (mode_reg == PM_NORMAL)
            sleep_rst_reg <= 1'b0;
    end

    // last reset cause: one-hot, replaced on each new reset
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cause_reg <= CAUSE_RST;
        else if (rst_allow && wr_ctrl && bus.wdata[CTRL_SWRST_BIT])
            cause_reg <= 4'(1 << CAUSE_SOFT);
        else if (rst_allow && wdog_expire)
            cause_reg <= 4'(1 << CAUSE_WDOG);
        else if (sleep_rst_reg && mode_reg == PM_NORMAL && !int_rst)
            cause_reg <= 4'(1 << CAUSE_SLEEP);
    end

    // system reset: hard reset in async, internal sources registered
    // registering costs one cycle of delay but keeps the output free of
    // glitches from the decode
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            sys_rst_b <= 1'b0;
        else
            sys_rst_b <= !int_rst && !(mode_reg == PM_WAKE);
    end

    // cpu clock: on in normal and while self-refresh entry is pending, so
    // software can still poll status; idle, sleep and wake stop it
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cpu_clk_en <= 1'b0;
        else
            cpu_clk_en <= mode_reg == PM_NORMAL || mode_reg == PM_SR_WAIT;
    end

    // per-unit gates: a unit ticks only while busy or forced on; one flop
    // each so the gate can be placed beside its unit
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit_clk
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
                unit_clk_en[u] <= 1'b0;
            else if (clk_mode_on)
                unit_clk_en[u] <= unit_busy[u] | clk_req_reg[u];
            else
                unit_clk_en[u] <= 1'b0;
        end
    end

    // power controls; self-refresh is requested before any clock drops
    // and the oscillator stops only once sleep is reached
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            power <= '{sr_req: 1'b0, osc_en: 1'b1, rtc_en: 1'b1};
        else
        begin
            power.rtc_en <= 1'b1;
            power.sr_req <= mode_reg == PM_SR_WAIT || mode_reg == PM_SLEEP;
            power.osc_en <= !(mode_reg == PM_SLEEP && !osc_keep_reg);
        end
    end

    // events: set wins over clear
    // an event landing in the clear cycle stays visible, so software
    // never loses a wake that raced its own acknowledge
    assign evt_set[EVT_IDLE_WAKE]  = mode_reg == PM_IDLE && any_irq;
    assign evt_set[EVT_SLEEP_WAKE] = mode_reg == PM_SLEEP && any_wake;
    assign evt_set[EVT_SR_DONE]    = mode_reg == PM_SR_WAIT && sr_ack;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            evt_reg <= '0;
        else if (wr_evt_clr)
            evt_reg <= (evt_reg & ~bus.wdata[EVT_W-1:0]) | evt_set;
        else
            evt_reg <= evt_reg | evt_set;
    end

    // level interrupt from enabled events
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(evt_reg & evt_en_reg);
    end

    // read mux; write-only and unmapped offsets read as zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (bus.addr)
            ADDR_CTRL:     rd_mux = 32'({osc_keep_reg, 3'b000});
            ADDR_STATUS:   rd_mux = 32'({sr_ack, mode_reg});
            ADDR_CAUSE:    rd_mux = 32'(cause_reg);
            ADDR_WAKE_EN:  rd_mux = 32'(wake_en_reg);
            ADDR_CLK_REQ:  rd_mux = 32'(clk_req_reg);
            ADDR_EVT_STAT: rd_mux = 32'(evt_reg);
            ADDR_EVT_EN:   rd_mux = 32'(evt_en_reg);
            default:       rd_mux = 32'h00000000;
        endcase
    end

    // read data, one cycle after the strobe and zero otherwise, so a
    // bus that ors several slaves needs no extra select
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 32'h00000000;
        else if (bus.rd)
            rdata <= rd_mux;
        else
            rdata <= 32'h00000000;
    end
endmodule : pmr_top

/* File: testbench/pmr_chk.sv */
/*
  pmr_chk: concurrent checks on the pmr_top ports.
  Assumes one clock domain; attached by the bind below.
*/
`timescale 1ns/1ps
module pmr_chk
    import pmr_pkg::*;
#(
    parameter int unsigned NUM_UNITS     = 8,
    parameter int unsigned NUM_IRQ       = 16,
    parameter int unsigned WAKE_SLOW_CNT = WAKE_SLOW_CYC
)
(
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst_b,
    // register port
    input wire pmr_bus_type          bus,
    input wire logic [31:0]          rdata,
    // interrupts and memory controller
    input wire logic [NUM_IRQ-1:0]   irq_pend,
    input wire logic [NUM_IRQ-1:0]   irq_enable,
    input wire logic                 sr_ack,
    // clocks and power
    input wire logic                 cpu_clk_en,
    input wire logic [NUM_UNITS-1:0] unit_clk_en,
    input wire pmr_power_type        power,
    input wire logic                 sys_rst_b
);
    localparam int unsigned LO_MAX = WAKE_SLOW_CNT + 4;
    logic [31:0] lo_cnt;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // length of the running system reset, bounds the wake latency
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            lo_cnt <= '0;
        else
            lo_cnt <= sys_rst_b ? '0 : lo_cnt + 32'h1;
    end

    rdata_quiet_a: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data not zero outside read cycle");
    rtc_kept_a: assert property (power.rtc_en)
        else $error("real-time clock stopped");
    osc_after_sr_a: assert property ($fell(power.osc_en) |-> $past(sr_ack))
        else $error("oscillator stopped before self-refresh ack");
    sleep_clocks_a: assert property ($rose(sr_ack) && power.sr_req
        |-> ##[1:3] (unit_clk_en == '0 && !cpu_clk_en))
        else $error("clocks still running in sleep");
    sleep_hold_a: assert property (power.sr_req && !cpu_clk_en && irq_pend == '0
        |=> power.sr_req)
        else $error("sleep left without wake interrupt");
    wake_rst_a: assert property ($fell(power.sr_req) |-> ##[0:2] !sys_rst_b)
        else $error("wake without system reset");
    wake_len_a: assert property (lo_cnt <= LO_MAX)
        else $error("system reset held too long");
    soft_rst_a: assert property (bus.wr && bus.addr == ADDR_CTRL
        && bus.wdata[CTRL_SWRST_BIT] && sys_rst_b |-> ##2 (!sys_rst_b [*8]))
        else $error("software reset pulse missing");
    idle_cpu_a: assert property (bus.wr && bus.addr == ADDR_CTRL && bus.wdata[2:0] == 3'h1
        && cpu_clk_en && !power.sr_req && sys_rst_b && (irq_pend & irq_enable) == '0
        |-> ##[1:2] !cpu_clk_en)
        else $error("cpu clock not stopped in idle");
    idle_wake_a: assert property (!cpu_clk_en && !power.sr_req && sys_rst_b
        && (irq_pend & irq_enable) != '0 |-> ##[1:3] cpu_clk_en)
        else $error("idle not left on enabled interrupt");

    sleep_c: cover property ($rose(sr_ack) && power.sr_req);
    wake_c: cover property ($fell(power.sr_req));
    soft_c: cover property ($fell(sys_rst_b));
endmodule : pmr_chk

bind pmr_top pmr_chk #(
    .NUM_UNITS(NUM_UNITS),
    .NUM_IRQ(NUM_IRQ),
    .WAKE_SLOW_CNT(WAKE_SLOW_CNT)
) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .irq_pend(irq_pend), .irq_enable(irq_enable), .sr_ack(sr_ack),
    .cpu_clk_en(cpu_clk_en), .unit_clk_en(unit_clk_en), .power(power),
    .sys_rst_b(sys_rst_b)
);

/* File: testbench/pmr_mem.sv */
/*
  pmr_mem: memory controller model answering self-refresh requests.
  Assumes the sequencer holds sr_req as a level until wake.
*/
`timescale 1ns/1ps
module pmr_mem
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // sequencer side
    input wire logic       sr_req,
    input wire logic [3:0] dly,
    output logic           sr_ack
);
    logic [3:0] wait_cnt;

    // ack rises dly+1 cycles after sr_req; ack is a level so a late look still sees it
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_cnt <= '0;
            sr_ack   <= 1'b0;
        end
        else if (!sr_req)
        begin
            wait_cnt <= '0;
            sr_ack   <= 1'b0;
        end
        else if (wait_cnt == dly)
            sr_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule : pmr_mem

/* File: testbench/tb_power_mode_reset_control.sv */
/*
  tb_power_mode_reset_control: directed scenarios for pmr_top.
  Assumes pmr_mem as memory controller and shortened wake counts.
*/
`timescale 1ns/1ps
module tb_power_mode_reset_control
    import pmr_pkg::*;
;
    localparam int unsigned FAST = 20;
    localparam int unsigned SLOW = 50;
    logic          ref_clk     = 1'b0;
    logic          rst_b       = 1'b0;
    pmr_bus_type   bus         = '0;
    logic          wdog_expire = 1'b0;
    logic [15:0]   irq_pend    = '0;
    logic [15:0]   irq_enable  = 16'h0001;
    logic [7:0]    unit_busy   = '0;
    logic [3:0]    dly         = 4'h8;
    logic [31:0]   rdata;
    logic          sr_ack, cpu_clk_en, sys_rst_b, irq;
    logic [7:0]    unit_clk_en;
    pmr_power_type power;
    int            mismatches  = 0;
    int            total_checks = 0;

    always #50 ref_clk = ~ref_clk;

    pmr_top #(.WAKE_FAST_CNT(FAST), .WAKE_SLOW_CNT(SLOW)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .wdog_expire(wdog_expire), .irq_pend(irq_pend), .irq_enable(irq_enable),
        .unit_busy(unit_busy), .sr_ack(sr_ack), .cpu_clk_en(cpu_clk_en),
        .unit_clk_en(unit_clk_en), .power(power), .sys_rst_b(sys_rst_b), .irq(irq));
    pmr_mem u_mem (.ref_clk(ref_clk), .rst_b(rst_b), .sr_req(power.sr_req),
        .dly(dly), .sr_ack(sr_ack));

    task automatic conclude;
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // let the edge's updates land before looking
    task automatic tick(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(logic [3:0] a, logic [31:0] exp, string nm);
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        chk(nm, exp, rdata);
    endtask : rd

    task automatic low_len(output int n);
        n = 0;
        for (int w = 0; w < 8 && sys_rst_b === 1'b1; w++) tick(1);
        while (sys_rst_b !== 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
    endtask : low_len

    task automatic t_hard;
        rst_b = 1'b0;
        tick(3);
        rst_b <= 1'b1;
        tick(2);
        chk("sys_rst_b", 1, sys_rst_b);
        rd(ADDR_CAUSE, 32'h1, "cause hard");
        rd(4'h9, 32'h0, "unmapped");
    endtask : t_hard

    task automatic t_busy;
        @(posedge ref_clk);
        unit_busy <= 8'h05;
        tick(3);
        chk("unit clocks busy", 8'h05, unit_clk_en);
        unit_busy <= 8'h00;
        tick(3);
        chk("unit clocks quiet", 8'h00, unit_clk_en);
        wr(ADDR_CLK_REQ, 32'h80);
        tick(2);
        chk("unit clocks forced", 8'h80, unit_clk_en);
        wr(ADDR_CLK_REQ, 32'h0);
    endtask : t_busy

    task automatic t_idle;
        wr(ADDR_CTRL, 32'h9);
        unit_busy <= 8'h03;
        tick(3);
        chk("idle clocks", 9'h003, {cpu_clk_en, unit_clk_en});
        irq_pend <= 16'h0001;
        tick(4);
        chk("idle wake cpu", 1, cpu_clk_en);
        irq_pend <= '0;
        unit_busy <= '0;
        rd(ADDR_EVT_STAT, 32'h1, "idle event");
        chk("irq masked", 0, irq);
        wr(ADDR_EVT_EN, 32'h1);
        tick(2);
        chk("irq raised", 1, irq);
        wr(ADDR_EVT_CLR, 32'h1);
        tick(2);
        chk("irq cleared", 0, irq);
        rd(ADDR_EVT_STAT, 32'h0, "event cleared");
    endtask : t_idle

    task automatic t_rst_src(logic sw, logic [31:0] cause);
        int n;
        if (sw)
            wr(ADDR_CTRL, 32'hc);
        else
        begin
            @(posedge ref_clk);
            wdog_expire <= 1'b1;
            @(posedge ref_clk);
            wdog_expire <= 1'b0;
        end
        low_len(n);
        chk("reset pulse", RST_PULSE_CYC, n);
        rd(ADDR_CAUSE, cause, "cause");
    endtask : t_rst_src

    task automatic t_sleep(logic osc, int cnt, logic [3:0] d);
        int n;
        dly <= d;
        wr(ADDR_WAKE_EN, 32'h2);
        unit_busy <= 8'hff;
        wr(ADDR_CTRL, {28'h0, osc, 3'h2});
        for (int w = 0; w < 6 && power.sr_req !== 1'b1; w++) tick(1);
        tick(3);
        if (d > 4'h5)
            chk("clocks before ack", 9'h1ff, {power.osc_en, unit_clk_en});
        for (int w = 0; w < 20 && sr_ack !== 1'b1; w++) tick(1);
        tick(4);
        chk("sleep outputs", {1'b0, 8'h00, osc, 1'b1},
            {cpu_clk_en, unit_clk_en, power.osc_en, power.rtc_en});
        rd(ADDR_STATUS, 32'ha, "status sleep");
        irq_pend <= 16'h0001;
        tick(5);
        chk("sleep kept", 1, power.sr_req);
        irq_pend <= 16'h0002;
        low_len(n);
        chk("wake length", 1, n >= cnt && n <= cnt + 2);
        irq_pend <= '0;
        unit_busy <= '0;
        rd(ADDR_CAUSE, 32'h8, "cause sleep");
    endtask : t_sleep

    initial
    begin
        t_hard;
        t_busy;
        t_idle;
        t_rst_src(1'b1, 32'h2);
        t_rst_src(1'b0, 32'h4);
        t_sleep(1'b0, SLOW, 4'h8);
        t_sleep(1'b1, FAST, 4'h1);
        t_hard;
        conclude;
    end

    // the scenarios need well under a thousand cycles
    initial
    begin
        #1_000_000;
        mismatches++;
        conclude;
    end
endmodule : tb_power_mode_reset_control
